// ===== design/asrx_fifo.sv
// Two-entry receive character FIFO with flush.
`timescale 1ns/1ps
`default_nettype none
module asrx_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core side
  asrx_fifo_if.store fi
);
  import asrx_pkg::*;

  logic [ENTRY_W-1:0] mem_reg [2];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  wire do_push = fi.push && (!fi.full || fi.pop);
  wire do_pop = fi.pop && !fi.empty;

  assign fi.full = count_reg[1];
  assign fi.empty = (count_reg == 2'h0);
  assign fi.head = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + {1'b0, do_push} - {1'b0, do_pop};

  always_ff @(posedge clk) begin
    if (rst || fi.flush) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (do_push) begin
        mem_reg[wr_ptr_reg] <= fi.wdata;
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (do_pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_next;
    end
  end
endmodule // asrx_fifo
`default_nettype wire

// ===== design/asrx_sync.sv
// Two flip-flop synchroniser for the serial input pin.
`timescale 1ns/1ps
`default_nettype none
module asrx_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic din,
  output logic dout
);
  logic meta_reg;

  // The line idles high, so both stages reset high.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // asrx_sync
`default_nettype wire

// ===== design/asrx_top.sv
// Asynchronous serial receiver with two-entry FIFO and register port.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module asrx_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register port
  input wire logic [asrx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [asrx_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [asrx_pkg::DATA_W-1:0] RDATA,
  // Serial line
  input wire logic RX_PIN,
  // Interrupt
  output logic IRQ
);
  import asrx_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  asrx_fifo_if fi ();
  asrx_state_t state_reg;
  asrx_state_t state_next;
  logic [3:0] ctrl_reg;
  logic [2:0] ien_reg;
  logic [2:0] evt_reg;
  logic [2:0] mask_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [BAUD_W-1:0] tick_reg;
  logic [BAUD_W-1:0] tick_next;
  logic [BITS_W-1:0] nbits_reg;
  logic [BITS_W-1:0] nbits_next;
  logic [CHAR_W-1:0] rx_shift_reg;
  logic [CHAR_W-1:0] shift_next;
  logic overrun_err_reg;
  logic rx_prev_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rx_s;
  logic [3:0] stat_word;
  logic [2:0] evt_set;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [BAUD_W-1:0] bit_reload(input logic [BAUD_W-1:0] period);
    return period - 16'h0001;
  endfunction

  // ----------------------------------------
  // Pin synchroniser and FIFO
  // ----------------------------------------
  asrx_sync u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .din(RX_PIN),
    .dout(rx_s)
  );

  asrx_fifo u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .fi(fi.store)
  );

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  wire serial_port_enable = ctrl_reg[CTRL_SERIAL_PORT_ENABLE];
  wire continuous_rx_enable = ctrl_reg[CTRL_CONTINUOUS_RX_ENABLE];
  wire nine_bit_rx_select = ctrl_reg[CTRL_RX9];
  wire addr_detect_enable = ctrl_reg[CTRL_ADDR_DETECT_ENABLE];
  wire rx_irq_enable = ien_reg[IEN_RX];
  wire peripheral_irq_enable = ien_reg[IEN_PERI];
  wire global_irq_enable = ien_reg[IEN_GLOB];
  wire rx_run = serial_port_enable && continuous_rx_enable;

  wire sel_ctrl = reg_hit(ADDR, OFS_CTRL);
  wire sel_stat = reg_hit(ADDR, OFS_STAT);
  wire sel_data = reg_hit(ADDR, OFS_DATA);
  wire sel_baud = reg_hit(ADDR, OFS_BAUD);
  wire sel_ien = reg_hit(ADDR, OFS_IEN);
  wire sel_evt = reg_hit(ADDR, OFS_EVT);
  wire sel_mask = reg_hit(ADDR, OFS_MASK);

  wire [3:0] ctrl_wr = WDATA[3:0];
  wire wr_ctrl = WR && sel_ctrl;
  wire wr_baud = WR && sel_baud;
  wire wr_ien = WR && sel_ien;
  wire wr_evt = WR && sel_evt;
  wire wr_mask = WR && sel_mask;

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  wire [BAUD_W-1:0] half_bit = {1'b0, baud_reg[BAUD_W-1:1]};
  wire tick_done = (tick_reg == '0);
  wire start_edge = rx_prev_reg && !rx_s;
  wire [BITS_W-1:0] char_bits = nine_bit_rx_select ? BITS_9 : BITS_8;

  // Character as it stands when the stop bit is sampled.
  wire [CHAR_W-1:0] char_word = nine_bit_rx_select ? rx_shift_reg :
                                {1'b0, rx_shift_reg[CHAR_W-1:1]};
  wire stop_sample = (state_reg == ASRX_STOP) && tick_done;
  wire framing_bad = !rx_s;
  wire addr_filter = addr_detect_enable && nine_bit_rx_select;
  wire keep_char = !addr_filter || char_word[CHAR_W-1];
  wire data_pop = RD && sel_data && !fi.empty;
  wire room = !fi.full || data_pop;

  // A completed character is accepted only with room and no overrun.
  wire char_done = stop_sample && rx_run && keep_char && !overrun_err_reg;
  wire accept = char_done && room;
  wire overrun_hit = char_done && !room;
  wire dropped = stop_sample && rx_run && !keep_char;

  // ----------------------------------------
  // Receive state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    tick_next = tick_done ? '0 : tick_reg - 16'h0001;
    nbits_next = nbits_reg;
    shift_next = rx_shift_reg;
    case (state_reg)
      ASRX_IDLE: begin
        tick_next = half_bit;
        nbits_next = '0;
        if (rx_run && start_edge) begin
          state_next = ASRX_START;
        end
      end
      ASRX_START: begin
        if (tick_done) begin
          tick_next = bit_reload(baud_reg);
          if (rx_s) begin
            state_next = ASRX_IDLE;
          end else begin
            state_next = ASRX_DATA;
          end
        end
      end
      ASRX_DATA: begin
        if (tick_done) begin
          tick_next = bit_reload(baud_reg);
          shift_next = {rx_s, rx_shift_reg[CHAR_W-1:1]};
          nbits_next = nbits_reg + 4'h1;
          if (nbits_reg + 4'h1 == char_bits) begin
            state_next = ASRX_STOP;
          end
        end
      end
      ASRX_STOP: begin
        if (tick_done) begin
          // A low stop bit is kept as a framing error; reception goes on.
          state_next = ASRX_IDLE;
        end
      end
      default: begin
        state_next = ASRX_IDLE;
      end
    endcase
    if (!rx_run) begin
      state_next = ASRX_IDLE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= ASRX_IDLE;
      tick_reg <= '0;
      nbits_reg <= '0;
    end else begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      nbits_reg <= nbits_next;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rx_shift_reg <= '0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_shift_reg <= shift_next;
      rx_prev_reg <= rx_s;
    end
  end

  // ----------------------------------------
  // FIFO control
  // ----------------------------------------
  assign fi.push = accept;
  assign fi.wdata = {framing_bad, char_word};
  assign fi.pop = data_pop;
  assign fi.flush = !serial_port_enable;

  // ----------------------------------------
  // Overrun flag
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      overrun_err_reg <= 1'b0;
    end else if (!rx_run) begin
      overrun_err_reg <= 1'b0;
    end else if (overrun_hit) begin
      overrun_err_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  // A disabled port shows no head character, even in the cycle before the flush lands.
  wire head_valid = serial_port_enable && !fi.empty;
  wire rx_pending_flag = rx_run && !fi.empty;
  wire framing_err = head_valid && fi.head[ENTRY_FRAMING_ERR];
  wire rx_ninth_bit = head_valid && fi.head[CHAR_W-1];
  // The flag reads clear as soon as reception stops, one cycle before the register.
  wire overrun_err = overrun_err_reg && rx_run;
  wire evt_irq = |(evt_reg & mask_reg);
  wire pend_irq = rx_pending_flag && rx_irq_enable && peripheral_irq_enable && global_irq_enable;

  // Status and event bits sit at their named field positions.
  always_comb begin
    stat_word = '0;
    stat_word[STAT_FRAMING_ERR] = framing_err;
    stat_word[STAT_OVERRUN_ERR] = overrun_err;
    stat_word[STAT_NINTH] = rx_ninth_bit;
    stat_word[STAT_PEND] = rx_pending_flag;
    evt_set = '0;
    evt_set[EVT_RX] = accept;
    evt_set[EVT_OVR] = overrun_hit;
    evt_set[EVT_DROP] = dropped;
  end

  assign IRQ = pend_irq || evt_irq;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_wr;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      baud_reg <= BAUD_RST;
    end else if (wr_baud) begin
      baud_reg <= WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ien_reg <= IEN_RST;
    end else if (wr_ien) begin
      ien_reg <= WDATA[2:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mask_reg <= EVT_RST;
    end else if (wr_mask) begin
      mask_reg <= WDATA[2:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      evt_reg <= EVT_RST;
    end else if (wr_evt) begin
      evt_reg <= (evt_reg & ~WDATA[2:0]) | evt_set;
    end else begin
      evt_reg <= evt_reg | evt_set;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    rdata_next = '0;
    if (sel_ctrl) begin
      rdata_next = {12'h000, ctrl_reg};
    end else if (sel_stat) begin
      rdata_next = {12'h000, stat_word};
    end else if (sel_data) begin
      rdata_next = {8'h00, fi.head[7:0]};
    end else if (sel_baud) begin
      rdata_next = baud_reg;
    end else if (sel_ien) begin
      rdata_next = {13'h0000, ien_reg};
    end else if (sel_evt) begin
      rdata_next = {13'h0000, evt_reg};
    end else if (sel_mask) begin
      rdata_next = {13'h0000, mask_reg};
    end
    if (sel_data && !head_valid) begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= '0;
    end
  end

endmodule // asrx_top
`default_nettype wire

// ===== inc/asrx_fifo_if.sv
// Connection between the receiver core and its character FIFO.
`timescale 1ns/1ps
`default_nettype none
interface asrx_fifo_if;
  logic push;
  logic pop;
  logic flush;
  logic [asrx_pkg::ENTRY_W-1:0] wdata;
  logic [asrx_pkg::ENTRY_W-1:0] head;
  logic full;
  logic empty;
  modport core (output push, pop, flush, wdata, input head, full, empty);
  modport store (input push, pop, flush, wdata, output head, full, empty);
endinterface
`default_nettype wire

// ===== inc/asrx_pkg.sv
// Constants and types shared by the serial receiver files.
package asrx_pkg;

  // ----------------------------------------
  // Bus and data widths
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CHAR_W = 9;
  localparam int ENTRY_W = 10;
  localparam int BAUD_W = 16;
  localparam int BITS_W = 4;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_DATA = 4'h2;
  localparam logic [3:0] OFS_BAUD = 4'h3;
  localparam logic [3:0] OFS_IEN = 4'h4;
  localparam logic [3:0] OFS_EVT = 4'h5;
  localparam logic [3:0] OFS_MASK = 4'h6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_SERIAL_PORT_ENABLE = 0;
  localparam int CTRL_CONTINUOUS_RX_ENABLE = 1;
  localparam int CTRL_RX9 = 2;
  localparam int CTRL_ADDR_DETECT_ENABLE = 3;
  localparam int STAT_FRAMING_ERR = 0;
  localparam int STAT_OVERRUN_ERR = 1;
  localparam int STAT_NINTH = 2;
  localparam int STAT_PEND = 3;
  localparam int IEN_RX = 0;
  localparam int IEN_PERI = 1;
  localparam int IEN_GLOB = 2;
  localparam int EVT_RX = 0;
  localparam int EVT_OVR = 1;
  localparam int EVT_DROP = 2;
  localparam int ENTRY_FRAMING_ERR = 9;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] IEN_RST = 3'h0;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0010;
  localparam logic [BITS_W-1:0] BITS_8 = 4'h8;
  localparam logic [BITS_W-1:0] BITS_9 = 4'h9;

  typedef enum logic [1:0] {
    ASRX_IDLE = 2'b00,
    ASRX_START = 2'b01,
    ASRX_DATA = 2'b10,
    ASRX_STOP = 2'b11
  } asrx_state_t;

endpackage

// ===== testbench/asrx_top_props.sv
// Port-level checks for the serial receiver.
`timescale 1ns/1ps
`default_nettype none
module asrx_top_props (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register port
  input wire logic [asrx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [asrx_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [asrx_pkg::DATA_W-1:0] RDATA,
  // Serial line and interrupt
  input wire logic RX_PIN,
  input wire logic IRQ
);
  import asrx_pkg::*;
  logic [3:0] ctrl_reg;
  logic [2:0] ien_reg;
  logic [2:0] mask_reg;
  wire rd_stat = RD && ADDR == OFS_STAT;
  wire rx_on = ctrl_reg[CTRL_SERIAL_PORT_ENABLE] && ctrl_reg[CTRL_CONTINUOUS_RX_ENABLE];
  // Shadow copies of the control, interrupt-enable and mask settings.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
      ien_reg <= IEN_RST;
      mask_reg <= 3'h0;
    end else if (WR) begin
      if (ADDR == OFS_CTRL) ctrl_reg <= WDATA[3:0];
      if (ADDR == OFS_IEN) ien_reg <= WDATA[2:0];
      if (ADDR == OFS_MASK) mask_reg <= WDATA[2:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_pend_needs_enable: assert property (rd_stat && !rx_on |=> !RDATA[STAT_PEND])
    else $error("pending flag set while receiver off");
  a_irq_chain: assert property (rd_stat && ien_reg == 3'h7 && mask_reg == 3'h0 |=> RDATA[STAT_PEND] == $past(IRQ))
    else $error("interrupt does not follow pending flag");
  a_evt_irq: assert property (RD && ADDR == OFS_EVT && ien_reg != 3'h7 |=> $past(IRQ) == |(RDATA[2:0] & mask_reg))
    else $error("interrupt does not follow masked events");
  a_irq_gated: assert property (ien_reg != 3'h7 && mask_reg == 3'h0 |-> !IRQ)
    else $error("interrupt without full enable chain");
  a_port_off_framing_err: assert property (rd_stat && !ctrl_reg[CTRL_SERIAL_PORT_ENABLE] |=> !RDATA[STAT_FRAMING_ERR])
    else $error("framing status kept with port off");
  a_ovr_cleared: assert property (rd_stat && !ctrl_reg[CTRL_CONTINUOUS_RX_ENABLE] |=> !RDATA[STAT_OVERRUN_ERR])
    else $error("overrun kept with receive off");
  a_flushed_data: assert property (RD && ADDR == OFS_DATA && !ctrl_reg[CTRL_SERIAL_PORT_ENABLE] ##1 1'h1 |-> RDATA == 16'h0)
    else $error("data left after port disable");
  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0)
    else $error("read data outside read slot");
  cover property (rd_stat ##1 RDATA[STAT_OVERRUN_ERR]);
  cover property (rd_stat ##1 RDATA[STAT_FRAMING_ERR]);
  cover property (rd_stat ##1 RDATA[STAT_NINTH]);
  cover property ($rose(IRQ));
endmodule // asrx_top_props
bind asrx_top asrx_top_props i_asrx_top_props (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .RX_PIN(RX_PIN), .IRQ(IRQ));
`default_nettype wire

// ===== testbench/asrx_tx_model.sv
// Remote serial transmitter that drives the receive line.
`timescale 1ns/1ps
`default_nettype none
module asrx_tx_model (
  // Clock
  input wire logic clk,
  // Serial line
  output logic line
);
  int period = 16;
  initial line = 1'h1;
  // Sends start, eight or nine bits LSB first, stop, then one idle bit.
  task automatic send(input logic [8:0] chr, input logic nine, input logic bad_stop);
    int n;
    n = nine ? 9 : 8;
    line <= 1'h0;
    repeat (period) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= chr[i];
      repeat (period) @(posedge clk);
    end
    line <= ~bad_stop;
    repeat (period) @(posedge clk);
    line <= 1'h1;
    repeat (period) @(posedge clk);
  endtask
endmodule // asrx_tx_model
`default_nettype wire

// ===== testbench/tb_async_serial_receiver_fifo.sv
// Self-checking bench for the serial receiver.
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_receiver_fifo;
  import asrx_pkg::*;
  logic core_clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  wire [DATA_W-1:0] rdata;
  wire rx_line;
  wire irq;
  int fails = 0;
  int check_count = 0;
  int seed = 32'h327f;
  logic rd_d = 1'h0;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] msk_q[$];
  logic [DATA_W-1:0] m;
  asrx_top i_asrx_top (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RX_PIN(rx_line), .IRQ(irq));
  asrx_tx_model i_asrx_tx_model (.clk(core_clk), .line(rx_line));
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk);
    wr <= 1'h0;
    @(posedge core_clk);
  endtask
  // Notes the expected value and mask, then reads.
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk);
    rd <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic finish_test;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read data stand in the cycle after the strobe.
  always @(posedge core_clk) rd_d <= rd;
  always @(negedge core_clk) begin
    if (rd_d === 1'h1) begin
      m = msk_q.pop_front();
      chk(rdata & m, exp_q.pop_front() & m);
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    finish_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [8:0] c[4];
    rst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 4'h0;
    wdata = 16'h0;
    for (int i = 0; i < 4; i++) c[i] = 9'($random(seed));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    for (int a = 0; a < 16; a++) begin
      if (a != OFS_BAUD) rd_reg(4'(a), 16'h0, 16'hffff);
    end
    rd_reg(OFS_BAUD, BAUD_RST, 16'hffff);
    wr_reg(OFS_CTRL, 16'h3);
    i_asrx_tx_model.send(c[0], 1'h0, 1'h0);
    fork
      i_asrx_tx_model.send(c[1], 1'h0, 1'h1);
      begin
        repeat (40) @(posedge core_clk);
        rd_reg(OFS_STAT, 16'h8, 16'hb);
        rd_reg(OFS_DATA, {8'h0, c[0][7:0]}, 16'hffff);
      end
    join
    rd_reg(OFS_STAT, 16'h9, 16'hb);
    rd_reg(OFS_DATA, {8'h0, c[1][7:0]}, 16'hffff);
    rd_reg(OFS_STAT, 16'h0, 16'h8);
    i_asrx_tx_model.send(c[2], 1'h0, 1'h0);
    wr_reg(OFS_IEN, 16'h7);
    chk_irq(irq, 1'h1);
    rd_reg(OFS_STAT, 16'h8, 16'h8);
    wr_reg(OFS_IEN, 16'h3);
    chk_irq(irq, 1'h0);
    wr_reg(OFS_MASK, 16'h1);
    chk_irq(irq, 1'h1);
    wr_reg(OFS_EVT, 16'h7);
    chk_irq(irq, 1'h0);
    wr_reg(OFS_MASK, 16'h2);
    rd_reg(OFS_DATA, {8'h0, c[2][7:0]}, 16'hffff);
    for (int i = 0; i < 3; i++) i_asrx_tx_model.send(c[i], 1'h0, 1'h0);
    rd_reg(OFS_STAT, 16'ha, 16'hb);
    rd_reg(OFS_EVT, 16'h3, 16'hffff);
    chk_irq(irq, 1'h1);
    rd_reg(OFS_DATA, {8'h0, c[0][7:0]}, 16'hffff);
    rd_reg(OFS_DATA, {8'h0, c[1][7:0]}, 16'hffff);
    i_asrx_tx_model.send(c[3], 1'h0, 1'h0);
    rd_reg(OFS_STAT, 16'h2, 16'ha);
    wr_reg(OFS_CTRL, 16'h1);
    rd_reg(OFS_STAT, 16'h0, 16'h2);
    wr_reg(OFS_CTRL, 16'h3);
    i_asrx_tx_model.send(c[0], 1'h0, 1'h1);
    i_asrx_tx_model.send(c[1], 1'h0, 1'h1);
    rd_reg(OFS_STAT, 16'h9, 16'h9);
    rd_reg(OFS_DATA, {8'h0, c[0][7:0]}, 16'hffff);
    rd_reg(OFS_STAT, 16'h9, 16'h9);
    wr_reg(OFS_CTRL, 16'h1);
    rd_reg(OFS_STAT, 16'h1, 16'h9);
    wr_reg(OFS_CTRL, 16'h0);
    rd_reg(OFS_STAT, 16'h0, 16'h9);
    wr_reg(OFS_CTRL, 16'h3);
    rd_reg(OFS_STAT, 16'h0, 16'h8);
    wr_reg(OFS_CTRL, 16'hf);
    i_asrx_tx_model.send({1'h0, c[2][7:0]}, 1'h1, 1'h0);
    i_asrx_tx_model.send({1'h1, c[3][7:0]}, 1'h1, 1'h0);
    rd_reg(OFS_STAT, 16'hc, 16'hf);
    rd_reg(OFS_EVT, 16'h4, 16'h4);
    rd_reg(OFS_DATA, {8'h0, c[3][7:0]}, 16'hffff);
    wr_reg(OFS_CTRL, 16'h7);
    i_asrx_tx_model.send({1'h0, c[2][7:0]}, 1'h1, 1'h0);
    rd_reg(OFS_STAT, 16'h8, 16'hf);
    rd_reg(OFS_DATA, {8'h0, c[2][7:0]}, 16'hffff);
    finish_test;
  end
endmodule // tb_async_serial_receiver_fifo
`default_nettype wire
